// ### design/wdc_top.sv
// Purpose: Watchdog on a 14-bit down counter with refresh window, protection mode and AXI4-Lite registers.
// Assumes: All inputs synchronous to core_clk_i; option bytes are static straps sampled after reset.
// Notes:   Writes answer one cycle after both address and data are held; reads answer one cycle after the address.
//
// Register access over AXI4-Lite and the address map are this design's own decisions.
`timescale 1ns/1ps
`include "wdc_consts.svh"
// Contract
// [R1] 14-bit counter decrements per count tick
// [R2] Source is CPU clock or slow/16
// [R3] Two-bit select field picks the source
// [R4] Start after reset or on start write
// [R5] Auto-start bit decides post-reset run
// [R6] Wait/stop halts only without protection
// [R7] Refresh is 00h then FFh in window
// [R8] Reload on reset, refresh and underflow
// [R9] Underflow: interrupt or reset; protected: reset
// [R10] Protection reset state from initial bit
// [R11] Software toggles protection when unlocked
// [R12] Underflow period field sets initial value
// [R13] Refresh window field limits acceptance
// [R14] Cause flag set on watchdog reset
// [R15] Wrong order or outside window ignored
module wdc_top
  import wdc_pkg::*;
#(
  parameter int CNT_W = `WDC_CNT_W
) (
  input  wire logic        core_clk_i,
  input  wire logic        resetn_i,
  input  wire logic        loco_pulse_i,
  input  wire logic        low_power_i,
  input  wire logic        auto_start_bit_i,
  input  wire logic        protect_initial_bit_i,
  input  wire logic [1:0]  underflow_period_field_i,
  input  wire logic [1:0]  refresh_window_field_i,
  input  wire logic        other_reset_i,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic             wdog_irq_o,
  output logic             wdog_reset_o
);

  logic [CNT_W-1:0] cnt_q;
  logic             run_q;
  logic             prot_q;
  logic             cause_q;
  logic             uflow_q;
  logic [7:0]       ctrl_q;
  logic             strap_done_q;
  logic [1:0]       ufs_q;
  logic [1:0]       rws_q;
  wdc_ref_state_t   ref_q;
  logic             irq_q;
  logic             wrst_q;

  // Straps are captured on the first clock after reset release.
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      strap_done_q <= 1'b0;
      ufs_q        <= 2'b00;
      rws_q        <= 2'b00;
    end else if (!strap_done_q) begin
      strap_done_q <= 1'b1;
      ufs_q        <= underflow_period_field_i; // R12
      rws_q        <= refresh_window_field_i; // R13
    end
  end

  // Underflow period code 0..3 gives initial values of 1/8, 1/4, 1/2 and full range.
  // Before the straps are latched, the pin itself gives the first reload value.
  wire [1:0]       ufs_now  = strap_done_q ? ufs_q : underflow_period_field_i;
  wire [CNT_W-1:0] init_val = CNT_W'({CNT_W{1'b1}} >> (2'd3 - ufs_now)); // R12
  // Window code 0..3 opens refresh in the last 25, 50, 75 or 100 percent of the period.
  wire [CNT_W+1:0] win_prod = (CNT_W+2)'(init_val) * (CNT_W+2)'({1'b0, rws_q} + 3'd1);
  wire [CNT_W-1:0] win_lim  = CNT_W'(win_prod >> 2);
  wire             in_window = (cnt_q <= win_lim); // R13

  // AXI4-Lite write channel: address and data taken in either order.
  logic       aw_have_q, w_have_q;
  logic       aw_rdy_q;
  logic       w_rdy_q;
  logic       ar_rdy_q;
  logic [7:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0]  w_strb_q;
  assign s_axi_awready = aw_rdy_q;
  assign s_axi_wready  = w_rdy_q;
  wire wr_fire = aw_have_q && w_have_q && !s_axi_bvalid;
  wire wr_lane0 = w_strb_q[0];
  wire [7:0] wr_byte = w_data_q[7:0];
  wire wr_start   = wr_fire && wr_lane0 && (aw_addr_q == `WDC_OFF_START);
  wire wr_refresh = wr_fire && wr_lane0 && (aw_addr_q == `WDC_OFF_REFRESH);
  wire wr_ctrl    = wr_fire && wr_lane0 && (aw_addr_q == `WDC_OFF_CTRL);
  wire wr_prot    = wr_fire && wr_lane0 && (aw_addr_q == `WDC_OFF_PROTECT);
  wire wr_status  = wr_fire && wr_lane0 && (aw_addr_q == `WDC_OFF_STATUS);
  wire wr_mapped  = (aw_addr_q == `WDC_OFF_START) || (aw_addr_q == `WDC_OFF_REFRESH) ||
                    (aw_addr_q == `WDC_OFF_CTRL) || (aw_addr_q == `WDC_OFF_PROTECT) ||
                    (aw_addr_q == `WDC_OFF_STATUS) || (aw_addr_q == `WDC_OFF_COUNT);

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      aw_have_q <= 1'b0;
      w_have_q  <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q  <= 32'h0000_0000;
      w_strb_q  <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_have_q <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end else if (wr_fire) begin
        w_have_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `WDC_RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_mapped ? `WDC_RESP_OKAY : `WDC_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Refresh sequencer: 00h arms and FFh completes, both only inside the window; anything else disarms.
  wire refresh_ok = wr_refresh && (ref_q == WDC_REF_ARMED) &&
                    (wr_byte == `WDC_REFRESH_SECOND) && in_window; // R7 R15
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ref_q <= WDC_REF_IDLE;
    end else if (wr_refresh) begin
      ref_q <= (wr_byte == `WDC_REFRESH_FIRST && in_window) ? WDC_REF_ARMED : WDC_REF_IDLE; // R15
    end
  end

  // Control and protection registers.
  wire prot_sticky = strap_done_q && protect_initial_bit_i;
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ctrl_q <= `WDC_CTRL_RST;
      prot_q <= 1'b0;
    end else begin
      if (wr_ctrl) ctrl_q <= wr_byte;
      if (!strap_done_q) prot_q <= protect_initial_bit_i; // R10
      else if (wr_prot && !protect_initial_bit_i) prot_q <= wr_byte[`WDC_PROT_EN]; // R11
    end
  end

  // Protection forces the slow oscillator and reset action.
  wdc_tick_if tk ();
  assign tk.src_sel = prot_q ? 2'b10 : {ctrl_q[`WDC_CTRL_SRC_HI], ctrl_q[`WDC_CTRL_SRC_LO]}; // R3
  wire count_en = run_q && strap_done_q && (prot_q || !low_power_i); // R6
  wdc_tick_gen u_tick (
    .core_clk_i   (core_clk_i),
    .resetn_i     (resetn_i),
    .loco_pulse_i (loco_pulse_i),
    .run_i        (count_en),
    .tk           (tk)
  );

  wire underflow = tk.tick && (cnt_q == '0);
  wire use_reset = prot_q || ctrl_q[`WDC_CTRL_ACT]; // R9

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cnt_q <= '1;
      run_q <= 1'b0;
    end else begin
      if (!strap_done_q) run_q <= !auto_start_bit_i; // R5
      else if (wr_start) run_q <= 1'b1; // R4
      if (!strap_done_q || refresh_ok || underflow) cnt_q <= init_val; // R8
      else if (tk.tick) cnt_q <= cnt_q - CNT_W'(1); // R1
    end
  end

  // Events and cause flag; hardware set wins over the other-reset clear and the software clear.
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      irq_q   <= 1'b0;
      wrst_q  <= 1'b0;
      cause_q <= 1'b0;
      uflow_q <= 1'b0;
    end else begin
      irq_q  <= underflow && !use_reset; // R9
      wrst_q <= underflow && use_reset; // R9
      if (underflow && use_reset) cause_q <= 1'b1; // R14
      else if (other_reset_i) cause_q <= 1'b0; // R14
      if (underflow) uflow_q <= 1'b1;
      else if (wr_status && wr_byte[`WDC_STAT_UFLOW]) uflow_q <= 1'b0;
    end
  end
  assign wdog_irq_o   = irq_q;
  assign wdog_reset_o = wrst_q;

  // AXI4-Lite read channel.
  assign s_axi_arready = ar_rdy_q;
  wire [31:0] rd_mux =
    (s_axi_araddr == `WDC_OFF_CTRL)    ? {24'h0, ctrl_q} :
    (s_axi_araddr == `WDC_OFF_PROTECT) ? {24'h0, prot_q, 7'h00} :
    (s_axi_araddr == `WDC_OFF_STATUS)  ? {29'h0, uflow_q, run_q, cause_q} :
    (s_axi_araddr == `WDC_OFF_COUNT)   ? 32'(cnt_q) : 32'h0000_0000;
  wire rd_mapped = (s_axi_araddr == `WDC_OFF_START) || (s_axi_araddr == `WDC_OFF_REFRESH) ||
                   (s_axi_araddr == `WDC_OFF_CTRL) || (s_axi_araddr == `WDC_OFF_PROTECT) ||
                   (s_axi_araddr == `WDC_OFF_STATUS) || (s_axi_araddr == `WDC_OFF_COUNT);
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `WDC_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_mux;
      s_axi_rresp  <= rd_mapped ? `WDC_RESP_OKAY : `WDC_RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Ready outputs are registered copies of the accept condition for the next cycle.
  wire aw_have_d = (s_axi_awvalid && s_axi_awready) || (aw_have_q && !wr_fire);
  wire w_have_d  = (s_axi_wvalid && s_axi_wready) || (w_have_q && !wr_fire);
  wire bvalid_d  = wr_fire || (s_axi_bvalid && !s_axi_bready);
  wire rvalid_d  = (s_axi_arvalid && s_axi_arready) || (s_axi_rvalid && !s_axi_rready);
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      aw_rdy_q <= 1'b1;
      w_rdy_q  <= 1'b1;
      ar_rdy_q <= 1'b1;
    end else begin
      aw_rdy_q <= !aw_have_d && !bvalid_d;
      w_rdy_q  <= !w_have_d && !bvalid_d;
      ar_rdy_q <= !rvalid_d;
    end
  end

  // Assertions.
  property p_dec;
    @(posedge core_clk_i) disable iff (!resetn_i)
      (tk.tick && cnt_q != '0 && !refresh_ok && strap_done_q) |=> (cnt_q == $past(cnt_q) - CNT_W'(1));
  endproperty
  a_dec: assert property (p_dec) else $error("Counter did not decrement."); // R1

  property p_reload;
    @(posedge core_clk_i) disable iff (!resetn_i)
      (underflow || refresh_ok) |=> (cnt_q == $past(init_val));
  endproperty
  a_reload: assert property (p_reload) else $error("Counter not reloaded."); // R8

  property p_prot_rst;
    @(posedge core_clk_i) disable iff (!resetn_i)
      (underflow && prot_q) |=> (wdog_reset_o && !wdog_irq_o && cause_q);
  endproperty
  a_prot_rst: assert property (p_prot_rst) else $error("Protected underflow gave no reset."); // R9

  property p_irq;
    @(posedge core_clk_i) disable iff (!resetn_i)
      (underflow && !use_reset) |=> (wdog_irq_o && !wdog_reset_o);
  endproperty
  a_irq: assert property (p_irq) else $error("Underflow interrupt missing."); // R9

  property p_halt;
    @(posedge core_clk_i) disable iff (!resetn_i)
      (low_power_i && !prot_q && strap_done_q && !refresh_ok) |=> (cnt_q == $past(cnt_q));
  endproperty
  a_halt: assert property (p_halt) else $error("Counter ran in low power without protection."); // R6

  property p_order;
    @(posedge core_clk_i) disable iff (!resetn_i)
      (wr_refresh && ref_q == WDC_REF_IDLE && tk.tick && cnt_q != '0) |=> (cnt_q != $past(init_val) || $past(init_val) == $past(cnt_q) - CNT_W'(1));
  endproperty
  a_order: assert property (p_order) else $error("Refresh without prior 00h."); // R15

  property p_window;
    @(posedge core_clk_i) disable iff (!resetn_i)
      refresh_ok |-> in_window;
  endproperty
  a_window: assert property (p_window) else $error("Refresh outside window."); // R13

  property p_prot_lock;
    @(posedge core_clk_i) disable iff (!resetn_i)
      (prot_sticky) |=> prot_q;
  endproperty
  a_prot_lock: assert property (p_prot_lock) else $error("Protection left despite initial bit."); // R10

  c_irq:     cover property (@(posedge core_clk_i) disable iff (!resetn_i) wdog_irq_o);
  c_rst:     cover property (@(posedge core_clk_i) disable iff (!resetn_i) wdog_reset_o);
  c_refresh: cover property (@(posedge core_clk_i) disable iff (!resetn_i) refresh_ok);

endmodule : wdc_top

// ### design/wdc_consts.svh
// Purpose: Register offsets, field positions, reset values and encodings of the watchdog down counter.
// Assumes: Byte addresses on a 32-bit AXI4-Lite register bus.
// Notes:   Definitions only.
`ifndef WDC_CONSTS_SVH
`define WDC_CONSTS_SVH

`define WDC_OFF_START      8'h00
`define WDC_OFF_REFRESH    8'h04
`define WDC_OFF_CTRL       8'h08
`define WDC_OFF_PROTECT    8'h0C
`define WDC_OFF_STATUS     8'h10
`define WDC_OFF_COUNT      8'h14

`define WDC_CTRL_SRC_LO    6
`define WDC_CTRL_SRC_HI    7
`define WDC_CTRL_ACT       0
`define WDC_PROT_EN        7
`define WDC_STAT_CAUSE     0
`define WDC_STAT_RUN       1
`define WDC_STAT_UFLOW     2

`define WDC_CTRL_RST       8'h00
`define WDC_REFRESH_FIRST  8'h00
`define WDC_REFRESH_SECOND 8'hFF
`define WDC_CNT_W          14
`define WDC_LOCO_DIV       16
`define WDC_RESP_OKAY      2'b00
`define WDC_RESP_SLVERR    2'b10

`endif

// ### design/wdc_pkg.sv
// Purpose: Types of the watchdog down counter.
// Assumes: Constants come from wdc_consts.svh.
// Notes:   Types only.
package wdc_pkg;
  typedef enum logic [1:0] {
    WDC_REF_IDLE  = 2'b00,
    WDC_REF_ARMED = 2'b01
  } wdc_ref_state_t;
endpackage : wdc_pkg

// ### design/wdc_tick_if.sv
// Purpose: Count-source tick carrier between the prescaler and the watchdog core.
// Assumes: Single clock domain.
// Notes:   One modport per side.
`timescale 1ns/1ps
interface wdc_tick_if;
  logic [1:0] src_sel;
  logic       tick;
  modport src (input src_sel, output tick);
  modport dst (output src_sel, input tick);
endinterface : wdc_tick_if

// ### design/wdc_tick_gen.sv
// Purpose: Produces one count-source tick per cycle, or one per 16 slow oscillator pulses.
// Assumes: loco_pulse_i is a one-cycle pulse per slow oscillator period, synchronous to core_clk_i.
// Notes:   Select code 2'b10 or 2'b11 picks the divided slow oscillator.
`timescale 1ns/1ps
`include "wdc_consts.svh"
module wdc_tick_gen (
  input  wire logic core_clk_i,
  input  wire logic resetn_i,
  input  wire logic loco_pulse_i,
  input  wire logic run_i,
  wdc_tick_if.src   tk
);
  logic [3:0] div_q;
  logic       slow_q;
  wire        use_loco = tk.src_sel[1];
  wire        div_wrap = loco_pulse_i && (div_q == 4'(`WDC_LOCO_DIV - 1));

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      div_q  <= 4'h0;
      slow_q <= 1'b0;
    end else begin
      if (loco_pulse_i) div_q <= div_q + 4'h1;
      slow_q <= div_wrap;
    end
  end

  assign tk.tick = run_i && (use_loco ? slow_q : 1'b1); // R2

endmodule : wdc_tick_gen

// ### bench/wdc_top_tb.sv
// Purpose: Self-checking bench for wdc_top over its AXI4-Lite registers and strap pins.
// Assumes: Bus signals are sampled at the falling edge and changed just after a rising edge.
// Notes:   Three strap setups, each entered through a fresh reset.
`timescale 1ns/1ps
`include "wdc_consts.svh"
module wdc_top_tb;
  import wdc_pkg::*;
  logic        core_clk_i, resetn_i, loco_pulse_i, low_power_i, other_reset_i;
  logic        auto_start_bit_i, protect_initial_bit_i;
  logic [1:0]  underflow_period_field_i, refresh_window_field_i;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rr;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, wdog_irq_o, wdog_reset_o;
  logic [13:0] iv, c1, c2;
  int          n_fail, compares, cyc, irq_n, rst_n, n, seed;
  logic [7:0]  sq [2][3];

  wdc_top wdc_top_inst (.core_clk_i(core_clk_i), .resetn_i(resetn_i), .loco_pulse_i(loco_pulse_i),
    .low_power_i(low_power_i), .auto_start_bit_i(auto_start_bit_i), .protect_initial_bit_i(protect_initial_bit_i),
    .underflow_period_field_i(underflow_period_field_i), .refresh_window_field_i(refresh_window_field_i),
    .other_reset_i(other_reset_i), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .wdog_irq_o(wdog_irq_o), .wdog_reset_o(wdog_reset_o));

  initial begin
    core_clk_i = 1'b0;
    forever #50 core_clk_i = ~core_clk_i;
  end

  always @(negedge core_clk_i) begin
    if (wdog_irq_o === 1'b1) irq_n++;
    if (wdog_reset_o === 1'b1) rst_n++;
  end

  always @(posedge core_clk_i) begin
    cyc++;
    if (cyc == 90000) begin
      n_fail++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : give_verdict

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  function automatic logic [13:0] init_of(input logic [1:0] ufp);
    return 14'h3FFF >> (2'd3 - ufp);
  endfunction : init_of

  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    bit ta, tw, tb;
    @(posedge core_clk_i);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    forever begin
      @(negedge core_clk_i);
      ta = s_axi_awvalid && (s_axi_awready === 1'b1);
      tw = s_axi_wvalid && (s_axi_wready === 1'b1);
      tb = s_axi_bvalid === 1'b1;
      rr = s_axi_bresp;
      @(posedge core_clk_i);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      if (tb) begin
        s_axi_bready <= 1'b0;
        break;
      end
    end
  endtask : axw

  task automatic axr(input logic [7:0] a);
    bit ta;
    @(posedge core_clk_i);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    forever begin
      @(negedge core_clk_i);
      ta = s_axi_arvalid && (s_axi_arready === 1'b1);
      rd = s_axi_rdata;
      rr = s_axi_rresp;
      if (s_axi_rvalid === 1'b1) begin
        @(posedge core_clk_i);
        s_axi_rready <= 1'b0;
        break;
      end
      @(posedge core_clk_i);
      if (ta) s_axi_arvalid <= 1'b0;
    end
  endtask : axr

  task automatic cnt(output logic [13:0] c);
    axr(`WDC_OFF_COUNT);
    c = rd[13:0];
  endtask : cnt

  task automatic refresh(input logic [7:0] a, input logic [7:0] b);
    axw(`WDC_OFF_REFRESH, {24'h0, a});
    axw(`WDC_OFF_REFRESH, {24'h0, b});
  endtask : refresh

  task automatic do_reset(input logic au, input logic pr, input logic [1:0] uf, input logic [1:0] rw);
    @(posedge core_clk_i);
    resetn_i <= 1'b0;
    auto_start_bit_i <= au;
    protect_initial_bit_i <= pr;
    underflow_period_field_i <= uf;
    refresh_window_field_i <= rw;
    repeat (2) @(posedge core_clk_i);
    resetn_i <= 1'b1;
    repeat (2) @(posedge core_clk_i);
    iv = init_of(uf);
  endtask : do_reset

  task automatic wait_pulse(input int lim, input bit rk);
    n = 0;
    do begin
      @(negedge core_clk_i);
      n++;
    end while (((rk ? wdog_reset_o : wdog_irq_o) !== 1'b1) && n < lim);
  endtask : wait_pulse

  initial begin
    {resetn_i, loco_pulse_i, low_power_i, other_reset_i, auto_start_bit_i, protect_initial_bit_i} = 6'h00;
    {underflow_period_field_i, refresh_window_field_i} = 4'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    s_axi_wstrb = 4'hF;
    seed = $urandom(27885);
    do_reset(1'b1, 1'b0, 2'($urandom % 2), 2'h3);
    axr(`WDC_OFF_CTRL);
    check("ctrl_rst", rd[7:0], `WDC_CTRL_RST);
    axr(`WDC_OFF_STATUS);
    check("status_rst", rd[2:0], 3'h0);
    axr(`WDC_OFF_PROTECT);
    check("prot_rst", rd[7], 1'b0);
    cnt(c1);
    check("count_stopped", c1, iv);
    axr(8'h18 + 8'($urandom % 4) * 8'h04);
    check("unmapped_rd", rr, `WDC_RESP_SLVERR);
    axw(8'h1C, $urandom);
    check("unmapped_wr", rr, `WDC_RESP_SLVERR);
    axw(`WDC_OFF_START, $urandom);
    axr(`WDC_OFF_STATUS);
    check("run_after_start", rd[1], 1'b1);
    for (int k = 0; k < 4; k++) begin
      axw(`WDC_OFF_CTRL, 32'(k) << 6);
      cnt(c1);
      repeat (20 + $urandom % 20) @(posedge core_clk_i);
      cnt(c2);
      check("src_sel", c1 == c2, k >= 2);
    end
    axw(`WDC_OFF_CTRL, 32'h0);
    low_power_i <= 1'b1;
    cnt(c1);
    repeat (30) @(posedge core_clk_i);
    cnt(c2);
    check("halt_low_power", c2, c1);
    low_power_i <= 1'b0;
    axw(`WDC_OFF_PROTECT, 32'h80);
    axr(`WDC_OFF_PROTECT);
    check("prot_set", rd[7], 1'b1);
    cnt(c1);
    repeat (30) @(posedge core_clk_i);
    cnt(c2);
    check("prot_slow_src", c2, c1);
    axw(`WDC_OFF_PROTECT, 32'h0);
    axr(`WDC_OFF_PROTECT);
    check("prot_clr", rd[7], 1'b0);
    repeat (100) @(posedge core_clk_i);
    refresh(`WDC_REFRESH_FIRST, `WDC_REFRESH_SECOND);
    cnt(c1);
    check("refresh_reload", c1 > iv - 14'd20, 1'b1);
    sq[0] = '{8'hFF, 8'h00, 8'h00};
    sq[1] = '{8'h00, 8'h01 + 8'($urandom % 254), 8'hFF};
    for (int k = 0; k < 2; k++) begin
      repeat (50) @(posedge core_clk_i);
      cnt(c1);
      for (int j = 0; j < 3; j++) axw(`WDC_OFF_REFRESH, {24'h0, sq[k][j]});
      cnt(c2);
      check("bad_refresh", c2 < c1, 1'b1);
    end
    wait_pulse(2 * iv + 100, 1'b0);
    rst_n = 0;
    wait_pulse(iv + 100, 1'b0);
    check("irq_period", n, iv + 1);
    check("no_reset_irq_mode", rst_n, 0);
    axr(`WDC_OFF_STATUS);
    check("uflow_sticky", rd[2], 1'b1);
    axw(`WDC_OFF_STATUS, 32'h4);
    axr(`WDC_OFF_STATUS);
    check("uflow_clr", rd[2], 1'b0);
    axw(`WDC_OFF_CTRL, 32'h1);
    irq_n = 0;
    wait_pulse(iv + 100, 1'b1);
    check("reset_action", wdog_reset_o, 1'b1);
    check("no_irq_rst_mode", irq_n, 0);
    axr(`WDC_OFF_STATUS);
    check("cause_set", rd[0], 1'b1);
    other_reset_i <= 1'b1;
    @(posedge core_clk_i);
    other_reset_i <= 1'b0;
    axr(`WDC_OFF_STATUS);
    check("cause_clr", rd[0], 1'b0);
    do_reset(1'b1, 1'b0, 2'h0, 2'h0);
    axw(`WDC_OFF_START, 32'h0);
    cnt(c1);
    refresh(`WDC_REFRESH_FIRST, `WDC_REFRESH_SECOND);
    cnt(c2);
    check("early_refresh", c2 < c1, 1'b1);
    repeat (iv - iv / 4 + 60) @(posedge core_clk_i);
    refresh(`WDC_REFRESH_FIRST, `WDC_REFRESH_SECOND);
    cnt(c2);
    check("window_refresh", c2 > iv / 4, 1'b1);
    do_reset(1'b0, 1'b1, 2'h0, 2'h3);
    axr(`WDC_OFF_STATUS);
    check("auto_run", rd[1], 1'b1);
    axw(`WDC_OFF_PROTECT, 32'h0);
    axr(`WDC_OFF_PROTECT);
    check("prot_locked", rd[7], 1'b1);
    axw(`WDC_OFF_CTRL, 32'h0);
    low_power_i <= 1'b1;
    loco_pulse_i <= 1'b1;
    irq_n = 0;
    wait_pulse((iv + 1) * 16 + 200, 1'b1);
    check("prot_reset", wdog_reset_o, 1'b1);
    check("prot_slow", n > iv * 8, 1'b1);
    check("prot_no_irq", irq_n, 0);
    give_verdict();
  end
endmodule : wdc_top_tb
